// ---- plc_led_pin_ctrl.sv ----
// Purpose: Status LEDs, hardware reset and shared power-down/irq pin
// Assumes: All inputs synchronous to clk; AHB-Lite single word access
// Notes:   Control, status and strap registers behind the bus slave
// What this block does
// - Mode 1: link LED on while link good
// - Modes 2,3: link LED blinks on activity
// - Speed LED on at 100, off at 10
// - Mode 1: shared LED shows tx/rx activity
// - Mode 2: shared LED shows collision
// - Mode 3: collision, or duplex when programmed
// - Test reset clears test logic asynchronously
// - Reset pin low 1 us starts reset
// - Hardware reset restores defaults, resamples straps
// - Shared pin defaults to active-low power-down
// - Interrupt mode: open-drain low on interrupt
// - Collision shown only in half duplex
`timescale 1ns/1ns
`default_nettype none
`include "plc_params.svh"

module plc_led_pin_ctrl
	import plc_pkg::*;
#(
	parameter int unsigned BLINK_HALF = `PLC_BLINK_HALF,
	parameter logic        LED_ON     = `PLC_LED_ON
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output var  logic                    hreadyout,
	output var  logic [31:0]             hrdata,
	output var  logic                    hresp,
	input  wire logic                    hwResetN,
	input  wire logic                    testRstN,
	input  wire plc_status_t             phyStatus,
	input  wire logic [`PLC_STRAP_W-1:0] strapIn,
	output var  logic [`PLC_STRAP_W-1:0] strapOut,
	output var  logic                    linkIndicatorOut,
	output var  logic                    speedIndicatorOut,
	output var  logic                    activityCollisionIndicatorOut,
	output var  logic                    powerDownOut,
	input  wire logic                    pdIrqPinIn,
	output var  logic                    pdIrqPinOut,
	output var  logic                    pdIrqPinOe
);

	// Least reset pulse, rounded up to whole cycles
	localparam int RST_MIN_CYC =
		(`PLC_RST_MIN_NS * `PLC_CLK_MHZ + 999) / 1000;
	localparam logic [7:0]  RST_MIN_CNT = 8'(RST_MIN_CYC);
	localparam logic [31:0] BLINK_LAST  = 32'(BLINK_HALF - 1);
	localparam logic        LED_OFF     = ~LED_ON;

	logic [7:0]              rstCnt_r;
	logic                    hwRst_r;
	logic                    resetAll;
	logic                    strapPend_r;
	logic [31:0]             blinkCnt_r;
	logic                    blinkPhase_r;
	logic                    testActive_r;
	plc_ctrl_t               ctrl_r;
	logic                    wrPend_r;
	logic [`PLC_OFS_W-1:0]   wrAddr_r;
	logic                    take;
	logic [31:0]             rdWord;
	plc_stat_t               stat;
	logic                    isMode1;
	logic                    isMode3;
	logic                    activity;
	logic                    colGated;
	logic                    linkNxt;
	logic                    actNxt;

	// Reset pin must stay low the full time; shorter dips are glitches
	always_ff @(posedge clk) begin
		if (rst || hwResetN) begin
			rstCnt_r <= 8'h00;
			hwRst_r  <= 1'b0;
		end else if (rstCnt_r != RST_MIN_CNT) begin
			rstCnt_r <= rstCnt_r + 8'h01;
		end else begin
			hwRst_r <= 1'b1;
		end
	end

	assign resetAll = rst | hwRst_r;

	// Straps re-taken on the first cycle out of system or pin reset
	always_ff @(posedge clk) begin
		if (rst) begin
			strapPend_r <= 1'b1;
			strapOut    <= `PLC_STRAP_RST;
		end else if (hwRst_r) begin
			strapPend_r <= 1'b1;
		end else if (strapPend_r) begin
			strapPend_r <= 1'b0;
			strapOut    <= strapIn;
		end
	end

	// Free-running blink divider; not touched by pin reset
	always_ff @(posedge clk) begin
		if (rst) begin
			blinkCnt_r   <= 32'h0000_0000;
			blinkPhase_r <= 1'b0;
		end else if (blinkCnt_r == BLINK_LAST) begin
			blinkCnt_r   <= 32'h0000_0000;
			blinkPhase_r <= ~blinkPhase_r;
		end else begin
			blinkCnt_r <= blinkCnt_r + 32'h0000_0001;
		end
	end

	// Test logic clears at once on test reset, no clock needed
	always_ff @(posedge clk or negedge testRstN) begin
		if (!testRstN) begin
			testActive_r <= 1'b0;
		end else if (resetAll) begin
			testActive_r <= 1'b0;
		end else begin
			testActive_r <= ctrl_r.testForce;
		end
	end

	// Bus address phase accepted on hready
	assign take = hsel & htrans[1] & hready;

	// Read-back view of live state
	always_comb begin
		stat            = '0;
		stat.blinkPhase = blinkPhase_r;
		stat.link       = phyStatus.link;
		stat.speed100   = phyStatus.speed100;
		stat.fullDuplex = phyStatus.fullDuplex;
		stat.activity   = activity;
		stat.colGated   = colGated;
		stat.powerDown  = powerDownOut;
		stat.irqCond    = phyStatus.irqCond;
	end

	// Register read mux; unmapped words read zero
	always_comb begin
		rdWord = 32'h0000_0000;
		case (haddr[`PLC_OFS_W-1:0])
			`PLC_OFS_CTRL: begin
				rdWord[4:0] = ctrl_r;
			end
			`PLC_OFS_STAT: begin
				rdWord[7:0] = stat;
			end
			`PLC_OFS_STRAP: begin
				rdWord[`PLC_STRAP_W-1:0] = strapOut;
			end
			default: begin
				rdWord = 32'h0000_0000;
			end
		endcase
		if (haddr[31:`PLC_OFS_W] != 20'h0_0000) begin
			rdWord = 32'h0000_0000;
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge clk) begin
		if (rst) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data lands in the data phase right after the address phase
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata <= rdWord;
		end
	end

	// Write address held for the data phase
	always_ff @(posedge clk) begin
		if (rst) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= '0;
		end else if (hready) begin
			wrPend_r <= take & hwrite &
				(haddr[31:`PLC_OFS_W] == 20'h0_0000);
			wrAddr_r <= haddr[`PLC_OFS_W-1:0];
		end
	end

	// Control register; pin reset returns it to defaults
	always_ff @(posedge clk) begin
		if (resetAll) begin
			ctrl_r.ledMode    <= `PLC_MODE_RST;
			ctrl_r.duplexShow <= 1'b0;
			ctrl_r.irqPinMode <= 1'b0;
			ctrl_r.testForce  <= 1'b0;
		end else if (wrPend_r && wrAddr_r == `PLC_OFS_CTRL) begin
			ctrl_r.ledMode    <= hwdata[`PLC_CTRL_MODE_LSB +: 2];
			ctrl_r.duplexShow <= hwdata[`PLC_CTRL_DPX_BIT];
			ctrl_r.irqPinMode <= hwdata[`PLC_CTRL_IRQ_BIT];
			ctrl_r.testForce  <= hwdata[`PLC_CTRL_TEST_BIT];
		end
	end

	// Mode decode; code 0 behaves as mode 1
	assign isMode1  = (ctrl_r.ledMode != `PLC_MODE2) &&
		(ctrl_r.ledMode != `PLC_MODE3);
	assign isMode3  = ctrl_r.ledMode == `PLC_MODE3;
	assign activity = phyStatus.txActive | phyStatus.rxActive;
	assign colGated = phyStatus.collision & ~phyStatus.fullDuplex;

	// Link LED: steady in mode 1, blinks on traffic otherwise
	assign linkNxt = phyStatus.link &
		(isMode1 | ~activity | blinkPhase_r);

	// Shared LED source selection
	always_comb begin
		if (isMode1) begin
			actNxt = activity;
		end else if (isMode3 && ctrl_r.duplexShow) begin
			actNxt = phyStatus.fullDuplex;
		end else begin
			actNxt = colGated;
		end
	end

	// LED drivers; lamp test forces all on
	always_ff @(posedge clk) begin
		if (resetAll) begin
			linkIndicatorOut              <= LED_OFF;
			speedIndicatorOut             <= LED_OFF;
			activityCollisionIndicatorOut <= LED_OFF;
		end else if (testActive_r) begin
			linkIndicatorOut              <= LED_ON;
			speedIndicatorOut             <= LED_ON;
			activityCollisionIndicatorOut <= LED_ON;
		end else begin
			linkIndicatorOut  <= linkNxt ? LED_ON : LED_OFF;
			speedIndicatorOut <= phyStatus.speed100 ?
				LED_ON : LED_OFF;
			activityCollisionIndicatorOut <= actNxt ? LED_ON : LED_OFF;
		end
	end

	// Shared pin: power-down input by default, open-drain irq if chosen
	always_ff @(posedge clk) begin
		if (resetAll) begin
			powerDownOut <= 1'b0;
			pdIrqPinOut  <= 1'b0;
			pdIrqPinOe   <= 1'b0;
		end else begin
			powerDownOut <= ~ctrl_r.irqPinMode & ~pdIrqPinIn;
			pdIrqPinOut  <= 1'b0; // Open drain only ever pulls low
			pdIrqPinOe   <= ctrl_r.irqPinMode &
				phyStatus.irqCond;
		end
	end

	// Checks; a reset-release edge still shows reset outputs, so skip it
	link_mode1_a: assert property (@(posedge clk)
		disable iff (resetAll) (isMode1 && !testActive_r && !resetAll) |=>
		((linkIndicatorOut == LED_ON) == $past(phyStatus.link)))
		else $error("link LED wrong in mode 1");

	link_blink_a: assert property (@(posedge clk)
		disable iff (resetAll)
		(!isMode1 && !testActive_r && phyStatus.link && activity) |=>
		((linkIndicatorOut == LED_ON) == $past(blinkPhase_r)))
		else $error("link LED not blinking on activity");

	speed_led_a: assert property (@(posedge clk)
		disable iff (resetAll) (!testActive_r && !resetAll) |=>
		((speedIndicatorOut == LED_ON) == $past(phyStatus.speed100)))
		else $error("speed LED wrong");

	act_mode1_a: assert property (@(posedge clk)
		disable iff (resetAll) (isMode1 && !testActive_r && !resetAll) |=>
		((activityCollisionIndicatorOut == LED_ON) == $past(activity)))
		else $error("activity LED wrong in mode 1");

	col_mode2_a: assert property (@(posedge clk)
		disable iff (resetAll)
		(ctrl_r.ledMode == `PLC_MODE2 && !testActive_r) |=>
		((activityCollisionIndicatorOut == LED_ON) == $past(colGated)))
		else $error("collision LED wrong in mode 2");

	dpx_mode3_a: assert property (@(posedge clk)
		disable iff (resetAll)
		(isMode3 && ctrl_r.duplexShow && !testActive_r) |=>
		((activityCollisionIndicatorOut == LED_ON) ==
		$past(phyStatus.fullDuplex)))
		else $error("duplex LED wrong in mode 3");

	col_fdx_a: assert property (@(posedge clk)
		disable iff (resetAll)
		(phyStatus.fullDuplex && !isMode1 && !testActive_r &&
		!(isMode3 && ctrl_r.duplexShow)) |=>
		activityCollisionIndicatorOut == LED_OFF)
		else $error("collision shown in full duplex");

	test_clear_a: assert property (@(posedge clk)
		!testRstN |-> !testActive_r)
		else $error("test logic not cleared by test reset");

	rst_qual_a: assert property (@(posedge clk)
		disable iff (rst) $rose(hwRst_r) |->
		($past(rstCnt_r) == RST_MIN_CNT && !$past(hwResetN)))
		else $error("pin reset taken too early");

	rst_dflt_a: assert property (@(posedge clk)
		disable iff (rst) hwRst_r |=>
		(ctrl_r.ledMode == `PLC_MODE_RST && !ctrl_r.irqPinMode))
		else $error("control not at defaults after pin reset");

	strap_take_a: assert property (@(posedge clk)
		disable iff (resetAll) (strapPend_r && !resetAll) |=>
		(strapOut == $past(strapIn) && !strapPend_r))
		else $error("straps not resampled");

	pwr_down_a: assert property (@(posedge clk)
		disable iff (resetAll) (!resetAll && !ctrl_r.irqPinMode &&
		!pdIrqPinIn) |=> (powerDownOut && !pdIrqPinOe))
		else $error("power-down input not honoured");

	irq_drive_a: assert property (@(posedge clk)
		disable iff (resetAll)
		(ctrl_r.irqPinMode && phyStatus.irqCond) |=>
		(pdIrqPinOe && !pdIrqPinOut && !powerDownOut))
		else $error("interrupt pin not pulled low");

	blink_rate_a: assert property (@(posedge clk)
		disable iff (rst) 1'b1 |=>
		($changed(blinkPhase_r) == ($past(blinkCnt_r) == BLINK_LAST)))
		else $error("blink divider out of step");

endmodule
`default_nettype wire

// ---- plc_params.svh ----
// Purpose: Constants of the LED, reset and shared-pin control block
// Assumes: 125 MHz system clock
// Notes:   Offsets are byte addresses on the register bus
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH

// Clock and hardware reset qualification time
`define PLC_CLK_MHZ       125
`define PLC_RST_MIN_NS    1000

// Register byte offsets
`define PLC_OFS_CTRL      12'h000
`define PLC_OFS_STAT      12'h004
`define PLC_OFS_STRAP     12'h008
`define PLC_OFS_W         12

// Control field positions
`define PLC_CTRL_MODE_LSB 0
`define PLC_CTRL_DPX_BIT  2
`define PLC_CTRL_IRQ_BIT  3
`define PLC_CTRL_TEST_BIT 4

// LED mode codes and reset values
`define PLC_MODE1         2'h1
`define PLC_MODE2         2'h2
`define PLC_MODE3         2'h3
`define PLC_MODE_RST      2'h1
`define PLC_STRAP_W       5
`define PLC_STRAP_RST     5'h00

// LED active level and half blink period in cycles (50 ms)
`define PLC_LED_ON        1'b1
`define PLC_BLINK_HALF    6250000

`endif

// ---- plc_pkg.sv ----
// Purpose: Types shared by the LED, reset and shared-pin control block
// Assumes: Nothing beyond the params header
// Notes:   Struct order fixes the read-back bit layout
package plc_pkg;

	// Live transceiver state sampled each cycle
	typedef struct packed {
		logic link;
		logic speed100;
		logic fullDuplex;
		logic txActive;
		logic rxActive;
		logic collision;
		logic irqCond;
	} plc_status_t;

	// Software control fields
	typedef struct packed {
		logic       testForce;
		logic       irqPinMode;
		logic       duplexShow;
		logic [1:0] ledMode;
	} plc_ctrl_t;

	// Status read-back word, bit 0 is blinkPhase
	typedef struct packed {
		logic irqCond;
		logic powerDown;
		logic colGated;
		logic activity;
		logic fullDuplex;
		logic speed100;
		logic link;
		logic blinkPhase;
	} plc_stat_t;

endpackage

// ---- plc_board_model.sv ----
// Purpose: Board side of the shared power-down/irq pin
// Assumes: Weak pull-up on the wire, system pulls low on request
// Notes:   Device drive wins; released wire reads the pull-up level
`timescale 1ns/1ns
`default_nettype none
module plc_board_model (
	input  wire logic pdIrqPinOut,
	input  wire logic pdIrqPinOe,
	input  wire logic pdReqLowN,
	output var  logic pinLevel
);
	// Wired-AND of device pull-down, system pull-down and pull-up
	always_comb begin
		pinLevel = 1'b1; // Pull-up when released
		if (!pdReqLowN)
			pinLevel = 1'b0; // System asks for power-down
		if (pdIrqPinOe)
			pinLevel = pdIrqPinOut; // Open-drain low
	end
endmodule
`default_nettype wire

// ---- tb_plc_led_pin_ctrl.sv ----
// Purpose: Self-checking bench of the LED and shared-pin block
// Assumes: Zero wait state bus slave, BLINK_HALF of 4
// Notes:   LED outputs are sampled at the falling edge, except the lamp-clear check 1 ns after a rising edge
`timescale 1ns/1ns
`default_nettype none
`include "plc_params.svh"
module tb_plc_led_pin_ctrl
	import plc_pkg::*;
;
	logic        clk, rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hwResetN, testRstN, powerDownOut, pinLevel;
	logic        pdIrqPinOut, pdIrqPinOe, pdReqLowN;
	logic        linkIndicatorOut, speedIndicatorOut;
	logic        activityCollisionIndicatorOut;
	logic [4:0]  strapIn, strapOut;
	plc_status_t st;
	int          errors, n_compared, cyc, cnt;

	plc_led_pin_ctrl #(.BLINK_HALF(4)) plc_led_pin_ctrl_inst (
		.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .hwResetN,
		.testRstN, .phyStatus(st), .strapIn, .strapOut,
		.linkIndicatorOut, .speedIndicatorOut,
		.activityCollisionIndicatorOut, .powerDownOut,
		.pdIrqPinIn(pinLevel), .pdIrqPinOut, .pdIrqPinOe);
	plc_board_model plc_board_model_inst (
		.pdIrqPinOut, .pdIrqPinOe, .pdReqLowN, .pinLevel);

	// Free-running clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Hang guard; normal run is well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One single word transfer; waits on hready in both phases
	task automatic xfer(input logic wr, input logic [31:0] a, d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic rd(input logic [31:0] a, e);
		xfer(1'b0, a, 32'h0000_0000);
		chk("bus read", e, q);
		chk("bus resp", 32'h0000_0000, {31'h0, hresp});
	endtask

	task automatic setSt(input logic [6:0] v);
		@(posedge clk);
		st <= plc_status_t'(v);
		repeat (3) @(posedge clk);
	endtask

	// Expected lamps in on-terms: link, speed, shared
	task automatic leds(input logic [2:0] e);
		@(negedge clk);
		chk("leds", {29'h0, `PLC_LED_ON ? e : ~e}, {linkIndicatorOut,
			speedIndicatorOut, activityCollisionIndicatorOut});
	endtask

	task automatic testDefaults();
		rd(`PLC_OFS_CTRL, 32'h0000_0001);
		rd(`PLC_OFS_STRAP, 32'h0000_0015);
		rd(32'h0000_000C, 32'h0000_0000);
	endtask

	task automatic testMode1();
		setSt(7'b1001000);
		for (int i = 0; i < 10; i++) leds(3'b101);
		setSt(7'b1100000);
		leds(3'b110);
		xfer(1'b1, `PLC_OFS_CTRL, 32'h0000_0000);
		setSt(7'b1001000);
		for (int i = 0; i < 10; i++) leds(3'b101);
	endtask

	// Link blinks half the time; collision only in half duplex
	task automatic testMode2();
		xfer(1'b1, `PLC_OFS_CTRL, 32'h0000_0002);
		setSt(7'b1001010);
		cnt = 0;
		for (int i = 0; i < 16; i++) begin
			@(negedge clk);
			cnt += (linkIndicatorOut === `PLC_LED_ON);
		end
		chk("blink count", 32'd8, cnt);
		setSt(7'b1000010);
		leds(3'b101);
		setSt(7'b1010010);
		leds(3'b100);
	endtask

	task automatic testMode3();
		xfer(1'b1, `PLC_OFS_CTRL, 32'h0000_0003);
		setSt(7'b1100010);
		leds(3'b111);
		xfer(1'b1, `PLC_OFS_CTRL, 32'h0000_0007);
		setSt(7'b1110000);
		leds(3'b111);
		setSt(7'b1100010);
		leds(3'b110);
	endtask

	task automatic testPin();
		xfer(1'b1, `PLC_OFS_CTRL, 32'h0000_0001);
		pdReqLowN <= 1'b0;
		setSt(7'b0000001);
		chk("power down", 32'h1, {31'h0, powerDownOut});
		chk("pin idle oe", 32'h0, {31'h0, pdIrqPinOe});
		xfer(1'b0, `PLC_OFS_STAT, 32'h0000_0000);
		chk("status", 32'h0000_00C0, q & 32'h0000_00FE);
		xfer(1'b1, `PLC_OFS_CTRL, 32'h0000_0009);
		pdReqLowN <= 1'b1;
		setSt(7'b0000001);
		chk("pin oe", 32'h1, {31'h0, pdIrqPinOe});
		chk("pin level", 32'h0, {31'h0, pinLevel});
		chk("no power down", 32'h0, {31'h0, powerDownOut});
		setSt(7'b0000000);
		chk("pin released", 32'h1, {31'h0, pinLevel});
	endtask

	// Short pulse ignored, long one restores defaults and straps
	task automatic testHwReset();
		xfer(1'b1, `PLC_OFS_CTRL, 32'h0000_0003);
		strapIn <= 5'h0A;
		hwResetN <= 1'b0;
		repeat (60) @(posedge clk);
		hwResetN <= 1'b1;
		rd(`PLC_OFS_CTRL, 32'h0000_0003);
		hwResetN <= 1'b0;
		repeat (130) @(posedge clk);
		hwResetN <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`PLC_OFS_CTRL, 32'h0000_0001);
		rd(`PLC_OFS_STRAP, 32'h0000_000A);
	endtask

	task automatic testLampReset();
		xfer(1'b1, `PLC_OFS_CTRL, 32'h0000_0011);
		setSt(7'b0000000);
		leds(3'b111);
		@(posedge clk);
		testRstN <= 1'b0;
		@(posedge clk);
		#1 chk("lamp cleared", 32'h0, {31'h0, linkIndicatorOut ==
			`PLC_LED_ON});
		leds(3'b000);
		@(posedge clk);
		testRstN <= 1'b1;
		xfer(1'b1, `PLC_OFS_CTRL, 32'h0000_0001);
	endtask

	// Main sequence
	initial begin
		{hsel, hwrite, haddr, hwdata, htrans, q} = '0;
		{errors, n_compared, cyc} = '0;
		hsize = 3'b010;
		st = '0;
		strapIn = 5'h15;
		{hwResetN, testRstN, pdReqLowN, rst} = 4'b1111;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		testDefaults();
		testMode1();
		testMode2();
		testMode3();
		testPin();
		testHwReset();
		testLampReset();
		test_done();
	end
endmodule
`default_nettype wire
